// file: rtl/adc_input_ref_select.sv
`timescale 1ns/1ps
`include "adc_input_ref_defines.svh"
// Overview of operation
// - Codes 0-7 select port 0 pins
// - Port 1/2 pin codes, 1B sensor; others reserved
// - Codes 1C-1F select supplies and ground
// - Upper bits read zero; reset selects ground
// - Disabled sensor floats, gives meaningless data
// - Ten-bit offset split over two registers
// - Low offset bits 5:0 read zero
// - Offset is per-part production value
// - Reference and ground multiplexers are provided
// - Two-bit reference source code mapping
// - Ground select picks pin or analog ground
// - Fast reference enabled only when needed
// - Sensor sampling always uses chip ground
module adc_input_ref_select
    import adc_input_ref_pkg::*;
#(
    parameter logic [9:0] TEMP_OFFSET_DEFAULT = 10'h200
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Special function register access
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    output logic [7:0] sfrRdata,
    // Production trim value, held stable by fuses
    input wire logic [9:0] trimOffset,
    // Converter timing
    input wire logic trackStart,
    input wire logic convActive,
    // Analog steering
    output input_route_t inputRoute,
    output ref_route_t refRoute,
    output logic sensorHighZ,
    output logic resultInvalid
);

    // =============================================
    // Decode helpers
    function automatic input_class_t classify(input logic [4:0] code);
        if (code <= `SEL_PORT0_LAST) begin
            classify = SRC_PORT0;
        end else if (code >= `SEL_PORT1_FIRST && code <= `SEL_PORT1_LAST) begin
            classify = SRC_PORT1;
        end else if (code >= `SEL_PORT2_FIRST && code <= `SEL_PORT2_LAST) begin
            classify = SRC_PORT2;
        end else if (code == `SEL_TEMP_SENSOR) begin
            classify = SRC_SENSOR;
        end else if (code == `SEL_GROUND) begin
            classify = SRC_GROUND;
        end else if (code >= `SEL_BATTERY) begin
            classify = SRC_SUPPLY;
        end else begin
            classify = SRC_RESERVED;
        end
    endfunction

    function automatic logic [7:0] pinOneHot(input logic [4:0] code);
        logic [7:0] v;
        v = 8'h00;
        unique case (classify(code))
            SRC_PORT0: v = 8'h01 << code[2:0];
            SRC_PORT1: v = 8'h10 << code[1:0];
            SRC_PORT2: v = 8'h01 << code[1:0];
            default: v = 8'h00;
        endcase
        pinOneHot = v;
    endfunction

    // =============================================
    // Registers
    logic [4:0] channelSel_r;
    logic [4:0] activeSel_r;
    logic [9:0] tempOffset_r;
    logic offsetLoaded_r;
    logic ground_reference_select_r;
    logic [1:0] refSrc_r;
    logic sensorEn_r;

    // Reset image of the reference control register, so fields can be picked out
    localparam logic [7:0] REF_CTL_RESET = `REFERENCE_CONTROL_RESET;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            channelSel_r <= `INPUT_CHANNEL_RESET;
        end else if (sfrWrite && sfrAddr == `ADDR_INPUT_CHANNEL) begin
            channelSel_r <= sfrWdata[4:0];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ground_reference_select_r <= REF_CTL_RESET[`REF_GND_BIT];
            refSrc_r <= REF_CTL_RESET[`REF_SRC_HI:`REF_SRC_LO];
            sensorEn_r <= REF_CTL_RESET[`SENSOR_EN_BIT];
        end else if (sfrWrite && sfrAddr == `ADDR_REFERENCE_CONTROL) begin
            ground_reference_select_r <= sfrWdata[`REF_GND_BIT];
            refSrc_r <= sfrWdata[`REF_SRC_HI:`REF_SRC_LO];
            sensorEn_r <= sfrWdata[`SENSOR_EN_BIT];
        end
    end

    // Trim captured after reset release; writes never reach it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tempOffset_r <= TEMP_OFFSET_DEFAULT;
            offsetLoaded_r <= 1'b0;
        end else if (!offsetLoaded_r) begin
            tempOffset_r <= trimOffset;
            offsetLoaded_r <= 1'b1;
        end
    end

    // =============================================
    // Input latched at start of tracking, held through conversion
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            activeSel_r <= `INPUT_CHANNEL_RESET;
        end else if (trackStart && !convActive) begin
            activeSel_r <= channelSel_r;
        end
    end

    // =============================================
    // Read data
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sfrRdata <= 8'h00;
        end else if (sfrRead) begin
            unique case (sfrAddr)
                `ADDR_INPUT_CHANNEL: sfrRdata <= {3'b000, channelSel_r};
                `ADDR_TEMP_OFFSET_HIGH: sfrRdata <= tempOffset_r[9:2];
                `ADDR_TEMP_OFFSET_LOW: sfrRdata <= {tempOffset_r[1:0], 6'b00_0000};
                `ADDR_REFERENCE_CONTROL: sfrRdata <= {2'b00, ground_reference_select_r, refSrc_r, sensorEn_r, 2'b00};
                default: sfrRdata <= 8'h00;
            endcase
        end
    end

    // =============================================
    // Analog steering
    input_class_t activeClass;
    assign activeClass = classify(activeSel_r);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            inputRoute <= '{channel: `SEL_GROUND, supplyTap: 3'b000, portPinOneHot: 8'h00, inputClass: SRC_GROUND};
        end else begin
            inputRoute.channel <= activeSel_r;
            inputRoute.inputClass <= activeClass;
            inputRoute.portPinOneHot <= pinOneHot(activeSel_r);
            inputRoute.supplyTap <= (activeClass == SRC_SUPPLY) ?
                (3'b001 << activeSel_r[1:0]) : 3'b000;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            refRoute <= '{refSource: REF_DIGITAL_1V8, groundSource: GND_PIN, fastRefEnable: 1'b0, sensorEnable: 1'b0};
            sensorHighZ <= 1'b1;
            resultInvalid <= 1'b0;
        end else begin
            refRoute.refSource <= ref_source_t'(refSrc_r);
            if (activeClass == SRC_SENSOR) begin
                refRoute.groundSource <= GND_CHIP;
            end else begin
                refRoute.groundSource <= ground_reference_select_r ? GND_ANALOG_PIN : GND_PIN;
            end
            refRoute.fastRefEnable <= (refSrc_r == 2'b11) && (trackStart || convActive);
            refRoute.sensorEnable <= sensorEn_r;
            sensorHighZ <= !sensorEn_r;
            resultInvalid <= (activeClass == SRC_RESERVED) ||
                (activeClass == SRC_SENSOR && !sensorEn_r);
        end
    end

    // =============================================
    // Checks
    // Bus and tracking events: channel write, tracking start, channel and reference reads
    sequence seqChannelWrite;
        sfrWrite && sfrAddr == `ADDR_INPUT_CHANNEL;
    endsequence

    sequence seqTrackIdle;
        trackStart && !convActive;
    endsequence

    sequence seqChannelRead;
        sfrRead && sfrAddr == `ADDR_INPUT_CHANNEL;
    endsequence

    sequence seqRefRead;
        sfrRead && sfrAddr == `ADDR_REFERENCE_CONTROL;
    endsequence

    chk_upper_bits_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        seqChannelRead |=> sfrRdata[7:5] == 3'b000)
        else $error("channel upper bits not zero");

    chk_channel_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
        seqChannelWrite |=> channelSel_r == $past(sfrWdata[4:0]))
        else $error("channel write not stored");

    chk_channel_readback: assert property (@(posedge clk_sys) disable iff (!reset_n)
        seqChannelRead |=> sfrRdata[4:0] == $past(channelSel_r))
        else $error("channel readback mismatch");

    chk_low_offset_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        sfrRead && sfrAddr == `ADDR_TEMP_OFFSET_LOW |=> sfrRdata[5:0] == 6'h00)
        else $error("offset low unused bits not zero");

    chk_offset_low_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
        offsetLoaded_r && sfrRead && sfrAddr == `ADDR_TEMP_OFFSET_LOW
        |=> sfrRdata[7:6] == $past(tempOffset_r[1:0]))
        else $error("offset low read mismatch");

    chk_offset_high_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
        offsetLoaded_r && sfrRead && sfrAddr == `ADDR_TEMP_OFFSET_HIGH
        |=> sfrRdata == $past(tempOffset_r[9:2]))
        else $error("offset high read mismatch");

    chk_offset_stable: assert property (@(posedge clk_sys) disable iff (!reset_n)
        offsetLoaded_r |=> $stable(tempOffset_r))
        else $error("offset changed after capture");

    chk_ref_readback: assert property (@(posedge clk_sys) disable iff (!reset_n)
        seqRefRead |=> sfrRdata[7:6] == 2'b00 && sfrRdata[1:0] == 2'b00)
        else $error("reference control unused bits not zero");

    chk_unmapped_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
        sfrRead && !(sfrAddr inside {`ADDR_INPUT_CHANNEL, `ADDR_TEMP_OFFSET_LOW, `ADDR_TEMP_OFFSET_HIGH,
        `ADDR_REFERENCE_CONTROL}) |=> sfrRdata == 8'h00)
        else $error("unmapped read not zero");

    chk_track_latch: assert property (@(posedge clk_sys) disable iff (!reset_n)
        seqTrackIdle |=> activeSel_r == $past(channelSel_r))
        else $error("select not taken at tracking start");

    chk_write_to_track: assert property (@(posedge clk_sys) disable iff (!reset_n)
        seqChannelWrite ##1 seqTrackIdle |=> activeSel_r == $past(sfrWdata[4:0], 2))
        else $error("written select not used at next tracking");

    chk_hold_in_conv: assert property (@(posedge clk_sys) disable iff (!reset_n)
        convActive |=> $stable(activeSel_r))
        else $error("input changed during conversion");

    chk_route_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
        1'b1 |=> inputRoute.channel == $past(activeSel_r))
        else $error("routed channel lags select");

    chk_port0_pin: assert property (@(posedge clk_sys) disable iff (!reset_n)
        activeSel_r <= `SEL_PORT0_LAST |=> $onehot(inputRoute.portPinOneHot) && !resultInvalid)
        else $error("port 0 pin not one-hot");

    chk_port1_pin: assert property (@(posedge clk_sys) disable iff (!reset_n)
        activeClass == SRC_PORT1
        |=> $onehot(inputRoute.portPinOneHot[7:4]) && inputRoute.portPinOneHot[3:0] == 4'h0)
        else $error("port 1 pin misrouted");

    chk_port2_pin: assert property (@(posedge clk_sys) disable iff (!reset_n)
        activeClass == SRC_PORT2
        |=> $onehot(inputRoute.portPinOneHot[3:0]) && inputRoute.portPinOneHot[7:4] == 4'h0)
        else $error("port 2 pin misrouted");

    chk_reserved_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
        activeClass == SRC_RESERVED |=> resultInvalid && inputRoute.portPinOneHot == 8'h00)
        else $error("reserved code not flagged");

    chk_supply_tap: assert property (@(posedge clk_sys) disable iff (!reset_n)
        activeClass == SRC_SUPPLY |=> $onehot(inputRoute.supplyTap))
        else $error("supply tap not one-hot");

    chk_battery_tap: assert property (@(posedge clk_sys) disable iff (!reset_n)
        activeSel_r == `SEL_BATTERY |=> inputRoute.supplyTap == 3'b001)
        else $error("battery tap misrouted");

    chk_ground_code: assert property (@(posedge clk_sys) disable iff (!reset_n)
        activeSel_r == `SEL_GROUND |=> inputRoute.inputClass == SRC_GROUND && inputRoute.portPinOneHot == 8'h00)
        else $error("ground code misrouted");

    chk_ref_source: assert property (@(posedge clk_sys) disable iff (!reset_n)
        1'b1 |=> refRoute.refSource == ref_source_t'($past(refSrc_r)))
        else $error("reference source mismatch");

    chk_sensor_ground: assert property (@(posedge clk_sys) disable iff (!reset_n)
        activeClass == SRC_SENSOR |=> refRoute.groundSource == GND_CHIP)
        else $error("sensor not on chip ground");

    chk_ground_select: assert property (@(posedge clk_sys) disable iff (!reset_n)
        activeClass != SRC_SENSOR && ground_reference_select_r |=> refRoute.groundSource == GND_ANALOG_PIN)
        else $error("analog ground not selected");

    chk_ground_pin: assert property (@(posedge clk_sys) disable iff (!reset_n)
        activeClass != SRC_SENSOR && !ground_reference_select_r |=> refRoute.groundSource == GND_PIN)
        else $error("ground pin not selected");

    chk_fast_ref_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !trackStart && !convActive |=> !refRoute.fastRefEnable)
        else $error("fast reference left on");

    chk_fast_ref_on: assert property (@(posedge clk_sys) disable iff (!reset_n)
        refSrc_r == 2'b11 && convActive |=> refRoute.fastRefEnable)
        else $error("fast reference not enabled");

    chk_fast_ref_other: assert property (@(posedge clk_sys) disable iff (!reset_n)
        refSrc_r != 2'b11 |=> !refRoute.fastRefEnable)
        else $error("fast reference on while not selected");

    chk_sensor_floats: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !sensorEn_r |=> sensorHighZ)
        else $error("disabled sensor not high impedance");

    chk_sensor_invalid: assert property (@(posedge clk_sys) disable iff (!reset_n)
        activeClass == SRC_SENSOR && !sensorEn_r |=> resultInvalid)
        else $error("disabled sensor result not flagged");

endmodule

// file: rtl/adc_input_ref_defines.svh
`ifndef ADC_INPUT_REF_DEFINES_SVH
`define ADC_INPUT_REF_DEFINES_SVH
// =============================================
// Register addresses
`define ADDR_INPUT_CHANNEL 8'hBB
`define ADDR_TEMP_OFFSET_LOW 8'hBD
`define ADDR_TEMP_OFFSET_HIGH 8'hBE
`define ADDR_REFERENCE_CONTROL 8'hD1
// =============================================
// Reset values
`define INPUT_CHANNEL_RESET 5'h1F
`define REFERENCE_CONTROL_RESET 8'h18
// =============================================
// Field positions
`define REF_GND_BIT 5
`define REF_SRC_HI 4
`define REF_SRC_LO 3
`define SENSOR_EN_BIT 2
// =============================================
// Input select codes
`define SEL_PORT0_LAST 5'h07
`define SEL_PORT1_FIRST 5'h0C
`define SEL_PORT1_LAST 5'h0F
`define SEL_PORT2_FIRST 5'h10
`define SEL_PORT2_LAST 5'h13
`define SEL_TEMP_SENSOR 5'h1B
`define SEL_BATTERY 5'h1C
`define SEL_CORE_REG 5'h1D
`define SEL_CONV_SUPPLY 5'h1E
`define SEL_GROUND 5'h1F
`endif

// file: rtl/adc_input_ref_pkg.sv
package adc_input_ref_pkg;
    typedef enum logic [2:0] {
        SRC_PORT0, SRC_PORT1, SRC_PORT2, SRC_SENSOR, SRC_SUPPLY, SRC_GROUND, SRC_RESERVED
    } input_class_t;
    typedef enum logic [1:0] {
        REF_PIN, REF_MAIN_SUPPLY, REF_DIGITAL_1V8, REF_FAST_1V65
    } ref_source_t;
    typedef enum logic [1:0] {
        GND_PIN, GND_ANALOG_PIN, GND_CHIP
    } ground_source_t;
    typedef struct packed {
        logic [4:0] channel;
        logic [2:0] supplyTap;
        logic [7:0] portPinOneHot;
        input_class_t inputClass;
    } input_route_t;
    typedef struct packed {
        ref_source_t refSource;
        ground_source_t groundSource;
        logic fastRefEnable;
        logic sensorEnable;
    } ref_route_t;
endpackage

// file: verification/sfr_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Software side of the register bus
module sfr_host_model (
    // Clock
    input wire logic clk_sys,
    // Register bus
    output logic [7:0] sfrAddr,
    output logic [7:0] sfrWdata,
    output logic sfrWrite,
    output logic sfrRead,
    input wire logic [7:0] sfrRdata
);
    initial begin
        sfrAddr = 8'h00;
        sfrWdata = 8'h00;
        sfrWrite = 1'h0;
        sfrRead = 1'h0;
    end
    // One-cycle write strobe; data scrambled once released
    task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWrite <= 1'h1;
        @(posedge clk_sys);
        sfrWrite <= 1'h0;
        sfrWdata <= ~d;
    endtask
    // Read data is taken the cycle after the strobe
    task automatic readReg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sfrAddr <= a;
        sfrRead <= 1'h1;
        @(posedge clk_sys);
        sfrRead <= 1'h0;
        #1 d = sfrRdata;
    endtask
endmodule

// file: verification/adc_input_ref_select_test.sv
`timescale 1ns/1ps
`include "adc_input_ref_defines.svh"
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin failCount++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module adc_input_ref_select_test
    import adc_input_ref_pkg::*;
;
    logic clk_sys = 1'h0;
    logic reset_n, sfrWrite, sfrRead, trackStart, convActive, sensorHighZ, resultInvalid;
    logic [7:0] sfrAddr, sfrWdata, sfrRdata, rd, refCtl;
    logic [9:0] trimOffset;
    logic [4:0] sel;
    input_route_t inputRoute;
    ref_route_t refRoute;
    int failCount = 0;
    int cmpCount = 0;
    int cycles = 0;
    int seed = 29;
    adc_input_ref_select uut (.clk_sys(clk_sys), .reset_n(reset_n), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
        .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdata(sfrRdata), .trimOffset(trimOffset),
        .trackStart(trackStart), .convActive(convActive), .inputRoute(inputRoute), .refRoute(refRoute),
        .sensorHighZ(sensorHighZ), .resultInvalid(resultInvalid));
    sfr_host_model host (.clk_sys(clk_sys), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrWrite(sfrWrite),
        .sfrRead(sfrRead), .sfrRdata(sfrRdata));
    always #20 clk_sys = ~clk_sys;
    // ==========================================
    // Expected routing
    function automatic input_class_t expClass(input logic [4:0] c);
        if (c <= `SEL_PORT0_LAST) return SRC_PORT0;
        if (c >= `SEL_PORT1_FIRST && c <= `SEL_PORT1_LAST) return SRC_PORT1;
        if (c >= `SEL_PORT2_FIRST && c <= `SEL_PORT2_LAST) return SRC_PORT2;
        if (c == `SEL_TEMP_SENSOR) return SRC_SENSOR;
        if (c >= `SEL_BATTERY && c <= `SEL_CONV_SUPPLY) return SRC_SUPPLY;
        if (c == `SEL_GROUND) return SRC_GROUND;
        return SRC_RESERVED;
    endfunction
    function automatic logic [7:0] expPins(input logic [4:0] c);
        case (expClass(c))
            SRC_PORT0: return 8'h01 << c[2:0];
            SRC_PORT1: return 8'h10 << c[1:0];
            SRC_PORT2: return 8'h01 << c[1:0];
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [2:0] expTap(input logic [4:0] c);
        return (expClass(c) == SRC_SUPPLY) ? 3'h1 << (c - `SEL_BATTERY) : 3'h0;
    endfunction
    function automatic ground_source_t expGnd(input logic [4:0] c, input logic g);
        if (c == `SEL_TEMP_SENSOR) return GND_CHIP;
        return g ? GND_ANALOG_PIN : GND_PIN;
    endfunction
    // ==========================================
    // Helpers
    task automatic pulseTrack();
        @(posedge clk_sys);
        trackStart <= 1'h1;
        @(posedge clk_sys);
        trackStart <= 1'h0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic stopTest();
        $display("Comparisons %0d, mismatches %0d", cmpCount, failCount);
        if (failCount == 0 && cmpCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            failCount++;
            stopTest();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        reset_n = 1'h0;
        trackStart = 1'h0;
        convActive = 1'h0;
        trimOffset = 10'($random(seed));
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'h1;
        repeat (2) @(posedge clk_sys);
        host.readReg(`ADDR_INPUT_CHANNEL, rd);
        `CHK(rd, 8'h1F)
        `CHK(inputRoute.inputClass, SRC_GROUND)
        host.readReg(`ADDR_REFERENCE_CONTROL, rd);
        `CHK(rd, 8'h18)
        `CHK(sensorHighZ, 1'h1)
        host.writeReg(`ADDR_TEMP_OFFSET_HIGH, ~trimOffset[9:2]);
        host.writeReg(`ADDR_TEMP_OFFSET_LOW, 8'hFF);
        host.readReg(`ADDR_TEMP_OFFSET_HIGH, rd);
        `CHK(rd, trimOffset[9:2])
        host.readReg(`ADDR_TEMP_OFFSET_LOW, rd);
        `CHK(rd, {trimOffset[1:0], 6'h00})
        host.readReg(8'h00, rd);
        `CHK(rd, 8'h00)
        // Every select code, with reference source from its low bits, random ground and sensor settings and unused bits
        for (int i = 0; i < 32; i++) begin
            sel = i[4:0];
            refCtl = 8'($random(seed));
            refCtl[4:3] = i[1:0];
            host.writeReg(`ADDR_REFERENCE_CONTROL, refCtl);
            host.writeReg(`ADDR_INPUT_CHANNEL, {3'($random(seed)), sel});
            host.readReg(`ADDR_INPUT_CHANNEL, rd);
            `CHK(rd, {3'h0, sel})
            host.readReg(`ADDR_REFERENCE_CONTROL, rd);
            `CHK(rd, refCtl & 8'h3C)
            pulseTrack();
            `CHK(inputRoute.inputClass, expClass(sel))
            `CHK(inputRoute.portPinOneHot, expPins(sel))
            `CHK(inputRoute.supplyTap, expTap(sel))
            `CHK(refRoute.refSource, ref_source_t'(refCtl[4:3]))
            `CHK(refRoute.groundSource, expGnd(sel, refCtl[5]))
            `CHK(sensorHighZ, ~refCtl[2])
            `CHK(resultInvalid, expClass(sel) == SRC_RESERVED || (sel == `SEL_TEMP_SENSOR && !refCtl[2]))
        end
        // Select frozen while converting; fast reference follows activity
        @(posedge clk_sys);
        convActive <= 1'h1;
        host.writeReg(`ADDR_INPUT_CHANNEL, 8'h03);
        pulseTrack();
        `CHK(inputRoute.channel, sel)
        `CHK(refRoute.fastRefEnable, 1'h1)
        @(posedge clk_sys);
        convActive <= 1'h0;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK(refRoute.fastRefEnable, 1'h0)
        pulseTrack();
        `CHK(inputRoute.channel, 5'h03)
        @(posedge clk_sys);
        reset_n <= 1'h0;
        #1;
        `CHK(inputRoute.channel, `SEL_GROUND)
        stopTest();
    end
endmodule
